// ==== hbcbl_lane_pack.sv ====
/*
 * Shared constants of the host bus front end, and the byte lane steering
 * module that maps queue byte streams to and from the host data lanes.
 * Assumes byte k of a stream word is byte k in network order (byte 0 first).
 */
package hbcbl_pkg;
    localparam int BYTE_W = 8;
    localparam int REG_W = 16;
    localparam int DATA_W = 32;
    localparam int CTL_W = 11;
    localparam int CTL_CS = 0;
    localparam int CTL_WE = 1;
    localparam int CTL_OE = 2;
    localparam int CTL_ALE = 3;
    localparam int CTL_MUXS = 4;
    localparam int CTL_WIDS = 5;
    localparam int CTL_ORDS = 6;
    localparam int CTL_ADDR = 7;
    localparam int ADDR_W = 4;
    localparam int AD_ADDR_LSB = 2;
    localparam logic [3:0] Q_IDX_LAST = 4'h7;
    localparam logic [3:0] ID_IDX = 4'h4;
    localparam logic [2:0] Q_CNT_16 = 3'h2;
    localparam logic [2:0] Q_CNT_32 = 3'h4;
    localparam logic [15:0] REG_UPPER_ZERO = 16'h0000;
    localparam logic [31:0] DOE_16 = 32'h0000FFFF;
    localparam logic [31:0] DOE_32 = 32'hFFFFFFFF;
endpackage

`timescale 1ns/1ps

module hbcbl_lane_pack
    import hbcbl_pkg::*;
(
    input wire logic wide,                  // 32-bit bus selected
    input wire logic little,                // Little endian selected
    input wire logic [31:0] bytes_in,       // Stream bytes to place on lanes
    output logic [31:0] lanes_out,          // Lanes carrying bytes_in
    input wire logic [31:0] lanes_in,       // Lanes from host
    output logic [31:0] bytes_out           // Stream bytes from lanes_in
);
    // Lane/byte map is its own inverse, so one index serves both ways
    function automatic int src_of(input int j, input logic w, input logic le);
        int r;
        r = j;
        if (!le) begin
            r = w ? 3 - j : (j < 2 ? 1 - j : j);
        end
        return r;
    endfunction

    genvar j;
    generate
        for (j = 0; j < 4; j++) begin : g_lane
            logic used;
            assign used = wide || (j < 2);
            assign lanes_out[BYTE_W*j +: BYTE_W] =
                used ? bytes_in[BYTE_W*src_of(j, wide, little) +: BYTE_W] : 8'h00;
            assign bytes_out[BYTE_W*j +: BYTE_W] =
                used ? lanes_in[BYTE_W*src_of(j, wide, little) +: BYTE_W] : 8'h00;
        end
    endgenerate
endmodule

// ==== hbcbl_host_port.sv ====
/*
 * Host parallel bus front end: strap capture at reset release, cycle
 * decode on chip select, register and queue lane steering.
 * Assumes host pins are asynchronous and slow against core_clk, and the
 * core answers a read pulse within one cycle on the same clock.
 */
`timescale 1ns/1ps

module hbcbl_host_port
    import hbcbl_pkg::*;
#(
    parameter logic [15:0] ID_VALUE = 16'hA5C3   // Arbitrary identification value
)
(
    input wire logic core_clk,                   // 10 MHz core clock
    input wire logic srst,                       // Synchronous reset, high
    input wire logic shared_addr_data_strap,     // Bus mode strap pin
    input wire logic width_strap,                // Bus width strap pin
    input wire logic byte_order_strap,           // Byte order strap pin
    input wire logic cs_n,                       // Chip select pin
    input wire logic we_n,                       // Write enable pin, low writes
    input wire logic oe_n,                       // Output enable pin
    input wire logic ale,                        // Address latch enable pin
    input wire logic [3:0] addr,                 // Word address pins
    input wire logic [31:0] data_in,             // Data lanes from host
    output logic [31:0] data_out,                // Data lanes to host
    output logic [31:0] data_oe,                 // Lane drive enables
    output logic cfg_valid,                      // Straps captured
    output logic muxed_mode,                     // Shared address/data bus
    output logic bus_32,                         // 32-bit bus
    output logic little_endian,                  // Little endian queue data
    output logic [3:0] acc_idx,                  // Accessed word index
    output logic reg_rd,                         // Register read pulse
    output logic reg_wr,                         // Register write pulse
    output logic [15:0] reg_wdata,               // Register write value
    input wire logic [15:0] reg_rdata,           // Register read value
    output logic q_rd,                           // Queue read pulse
    input wire logic [31:0] q_rd_bytes,          // Queue bytes, byte 0 first
    output logic q_wr,                           // Queue write pulse
    output logic [31:0] q_wr_bytes,              // Queue bytes, byte 0 first
    output logic [2:0] q_wr_count                // Valid bytes in q_wr_bytes
);
    typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_DRIVE, ST_WRITE} hbcbl_st_t;

    typedef struct packed {
        logic [CTL_W-1:0] ctl1;
        logic [CTL_W-1:0] ctl2;
        logic [DATA_W-1:0] dat1;
        logic [DATA_W-1:0] dat2;
        logic cs_prev;
        logic cfg_done;
        logic muxed;
        logic wide;
        logic little;
        logic [ADDR_W-1:0] ale_addr;
        logic [ADDR_W-1:0] idx;
        hbcbl_st_t st;
        logic [DATA_W-1:0] wlat;
        logic reg_rd;
        logic reg_wr;
        logic q_rd;
        logic q_wr;
        logic [REG_W-1:0] wdata;
        logic [DATA_W-1:0] q_wbytes;
        logic [2:0] q_count;
        logic [DATA_W-1:0] dout;
        logic [DATA_W-1:0] doe;
    } hbcbl_state_t;

    localparam hbcbl_state_t S_RST = '{st: ST_IDLE, default: '0};

    hbcbl_state_t s;
    hbcbl_state_t next_s;
    logic [CTL_W-1:0] pins;
    logic [31:0] rd_lanes;
    logic [31:0] wr_bytes;

    assign pins = {addr, byte_order_strap, width_strap, shared_addr_data_strap,
                   ale, oe_n, we_n, cs_n};

    hbcbl_lane_pack u_pack (
        .wide(s.wide),
        .little(s.little),
        .bytes_in(q_rd_bytes),
        .lanes_out(rd_lanes),
        .lanes_in(s.wlat),
        .bytes_out(wr_bytes)
    );

    always_comb begin
        logic cs2;
        logic fall;
        logic [ADDR_W-1:0] a;
        cs2 = s.ctl2[CTL_CS];
        fall = s.cs_prev && !cs2;
        a = '0;
        next_s = s;
        next_s.ctl1 = pins;
        next_s.ctl2 = s.ctl1;
        next_s.dat1 = data_in;
        next_s.dat2 = s.dat1;
        next_s.cs_prev = cs2;
        next_s.reg_rd = 1'b0;
        next_s.reg_wr = 1'b0;
        next_s.q_rd = 1'b0;
        next_s.q_wr = 1'b0;
        if (s.ctl2[CTL_ALE]) begin
            next_s.ale_addr = s.dat2[AD_ADDR_LSB +: ADDR_W];
        end
        // First cycle after release captures the straps
        if (!s.cfg_done) begin
            next_s.cfg_done = 1'b1;
            next_s.muxed = s.ctl2[CTL_MUXS];
            next_s.wide = s.ctl2[CTL_WIDS];
            next_s.little = s.ctl2[CTL_ORDS];
        end
        unique case (s.st)
            ST_IDLE: begin
                if (fall && s.cfg_done) begin
                    a = s.muxed ? s.ale_addr : s.ctl2[CTL_ADDR +: ADDR_W];
                    next_s.idx = a;
                    if (s.ctl2[CTL_WE]) begin
                        next_s.q_rd = (a <= Q_IDX_LAST) && (a != ID_IDX);
                        next_s.reg_rd = (a > Q_IDX_LAST) && (a != ID_IDX);
                        next_s.st = ST_ISSUE;
                    end else begin
                        next_s.wlat = s.dat2;
                        next_s.st = ST_WRITE;
                    end
                end
            end
            ST_ISSUE: begin
                next_s.st = ST_WAIT;
            end
            ST_WAIT: begin
                // Identification word sits inside the queue index range
                if (s.idx == ID_IDX) begin
                    next_s.dout = {REG_UPPER_ZERO, ID_VALUE};
                end else if (s.idx <= Q_IDX_LAST) begin
                    next_s.dout = rd_lanes;
                end else begin
                    next_s.dout = {REG_UPPER_ZERO, reg_rdata};
                end
                next_s.st = ST_DRIVE;
            end
            ST_DRIVE: begin
                if (cs2) begin
                    next_s.doe = '0;
                    next_s.st = ST_IDLE;
                end else if (!s.ctl2[CTL_OE]) begin
                    next_s.doe = s.wide ? DOE_32 : DOE_16;
                end else begin
                    next_s.doe = '0;
                end
            end
            ST_WRITE: begin
                if (cs2) begin
                    if (s.idx <= Q_IDX_LAST && s.idx != ID_IDX) begin
                        next_s.q_wr = 1'b1;
                        next_s.q_wbytes = wr_bytes;
                        next_s.q_count = s.wide ? Q_CNT_32 : Q_CNT_16;
                    end else if (s.idx > Q_IDX_LAST) begin
                        next_s.reg_wr = 1'b1;
                        next_s.wdata = s.wlat[REG_W-1:0];
                    end
                    next_s.st = ST_IDLE;
                end else begin
                    next_s.wlat = s.dat2;
                end
            end
        endcase
        // Synchronisers keep running in reset so straps are valid at release
        if (srst) begin
            next_s = S_RST;
            next_s.ctl1 = pins;
            next_s.ctl2 = s.ctl1;
            next_s.dat1 = data_in;
            next_s.dat2 = s.dat1;
            next_s.cs_prev = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        s <= next_s;
    end

    assign data_out = s.dout;
    assign data_oe = s.doe;
    assign cfg_valid = s.cfg_done;
    assign muxed_mode = s.muxed;
    assign bus_32 = s.wide;
    assign little_endian = s.little;
    assign acc_idx = s.idx;
    assign reg_rd = s.reg_rd;
    assign reg_wr = s.reg_wr;
    assign reg_wdata = s.wdata;
    assign q_rd = s.q_rd;
    assign q_wr = s.q_wr;
    assign q_wr_bytes = s.q_wbytes;
    assign q_wr_count = s.q_count;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence read_start_s;
        s.st == ST_IDLE && s.cs_prev && !s.ctl2[CTL_CS] && s.cfg_done && s.ctl2[CTL_WE];
    endsequence
    sequence read_steps_s;
        s.st == ST_ISSUE ##1 s.st == ST_WAIT ##1 s.st == ST_DRIVE;
    endsequence

    cfg_hold_a: assert property (s.cfg_done && $past(s.cfg_done) |->
        $stable({s.muxed, s.wide, s.little})) else $error("bus mode changed after capture");
    mode_latch_a: assert property ($rose(s.cfg_done) |->
        s.muxed == $past(s.ctl2[CTL_MUXS])) else $error("bus mode strap not latched");
    width_latch_a: assert property ($rose(s.cfg_done) |->
        s.wide == $past(s.ctl2[CTL_WIDS])) else $error("width strap not latched");
    order_latch_a: assert property ($rose(s.cfg_done) |->
        s.little == $past(s.ctl2[CTL_ORDS])) else $error("byte order strap not latched");
    read_flow_a: assert property (read_start_s |=> read_steps_s)
        else $error("read cycle steps out of order");
    reg_upper_a: assert property (s.st == ST_DRIVE && s.idx > Q_IDX_LAST |->
        s.dout[31:16] == REG_UPPER_ZERO) else $error("register read drove upper lanes");
    id_read_a: assert property (s.st == ST_WAIT && s.idx == ID_IDX |=>
        s.dout == {REG_UPPER_ZERO, ID_VALUE}) else $error("identification value wrong");
    reg_write_a: assert property (s.reg_wr |->
        s.wdata == $past(s.wlat[15:0])) else $error("register write took wrong lanes");
    be16_order_a: assert property (s.q_wr && !s.wide && !s.little |->
        s.q_wbytes[7:0] == $past(s.wlat[15:8])) else $error("big endian 16 order wrong");
    be32_order_a: assert property (s.q_wr && s.wide && !s.little |->
        s.q_wbytes[7:0] == $past(s.wlat[31:24])) else $error("big endian 32 order wrong");
    le16_order_a: assert property (s.q_wr && !s.wide && s.little |->
        s.q_wbytes[15:0] == $past(s.wlat[15:0])) else $error("little endian 16 order wrong");
    le32_order_a: assert property (s.q_wr && s.wide && s.little |->
        s.q_wbytes == $past(s.wlat)) else $error("little endian 32 order wrong");
    lane_width_a: assert property (s.doe[31:16] != 16'h0000 |-> s.wide)
        else $error("upper lanes driven on 16-bit bus");
endmodule

// ==== hbcbl_host_model.sv ====
/*
 * Host bus controller model: chip select, strobes, address and data lanes.
 * Assumes the bench resolves the lane wire and feeds it back on lanes.
 */
`timescale 1ns/1ps

module hbcbl_host_model (
    input wire logic core_clk,          // Core clock
    input wire logic [31:0] lanes,      // Resolved data lanes
    input wire logic [31:0] data_oe,    // Device lane enables
    output logic cs_n,                  // Chip select
    output logic we_n,                  // Write enable
    output logic oe_n,                  // Output enable
    output logic ale,                   // Address latch enable
    output logic [3:0] addr,            // Word address
    output logic [31:0] host_d          // Host lane drive
);
    initial begin
        cs_n = 1'b1;
        we_n = 1'b1;
        oe_n = 1'b1;
        ale = 1'b0;
        addr = 4'h0;
        host_d = 32'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic put_addr(input logic [3:0] idx);
        tick(1);
        ale = 1'b1;
        host_d = {26'h0, idx, 2'h0};
        tick(3);
        ale = 1'b0;
        host_d = ~host_d; // Inverted lanes, address no longer driven
        tick(3);
    endtask

    task automatic rd(input logic mux, input logic [3:0] idx, output logic [31:0] val,
                      output logic [31:0] oe, output logic ok);
        ok = 1'b0;
        if (mux) put_addr(idx);
        tick(1);
        cs_n = 1'b0;
        we_n = 1'b1;
        oe_n = 1'b0;
        addr = mux ? ~idx : idx;
        tick(2);
        addr = ~idx;
        for (int i = 0; i < 14 && !ok; i++) begin
            tick(1);
            ok = (data_oe[0] === 1'b1);
        end
        val = lanes;
        oe = data_oe;
        tick(1);
        cs_n = 1'b1;
        oe_n = 1'b1;
        tick(5);
    endtask

    task automatic wr(input logic mux, input logic [3:0] idx, input logic [31:0] val);
        if (mux) put_addr(idx);
        tick(1);
        cs_n = 1'b0;
        we_n = 1'b0;
        addr = mux ? ~idx : idx;
        host_d = val;
        tick(2);
        addr = ~idx;
        tick(6);
        cs_n = 1'b1;
        tick(2);
        we_n = 1'b1;
        host_d = ~val;
        tick(6);
    endtask
endmodule

// ==== hbcbl_host_port_tb.sv ====
/*
 * Self-checking bench of the host port across four strap settings.
 * Assumes the host model above and a core side held static per access.
 */
`timescale 1ns/1ps

module hbcbl_host_port_tb
    import hbcbl_pkg::*;
;
    localparam logic [15:0] ID_VAL = 16'h5A3C; // Arbitrary identification value
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic mux_s = 1'b0;
    logic w_s = 1'b0;
    logic le_s = 1'b0;
    logic cs_n, we_n, oe_n, ale, cfg_valid, muxed_mode, bus_32, little_endian;
    logic reg_rd, reg_wr, q_rd, q_wr, cm, cw, cl;
    logic [3:0] addr, acc_idx, last_idx;
    logic [31:0] host_d, data_in, data_out, data_oe, q_wr_bytes, last_qwb, last_oe;
    logic [31:0] q_rd_bytes = 32'h0;
    logic [15:0] reg_wdata, last_rwd;
    logic [15:0] reg_rdata = 16'h0;
    logic [2:0] q_wr_count, last_qwc;
    int num_errors = 0;
    int checks_done = 0;
    int n_qrd = 0;
    int n_qwr = 0;
    int n_rrd = 0;
    int n_rwr = 0;

    always #50 core_clk = ~core_clk;
    assign data_in = (data_out & data_oe) | (host_d & ~data_oe);

    hbcbl_host_port #(.ID_VALUE(ID_VAL)) u_hbcbl_host_port (
        .core_clk(core_clk), .srst(srst), .shared_addr_data_strap(mux_s),
        .width_strap(w_s), .byte_order_strap(le_s), .cs_n(cs_n), .we_n(we_n),
        .oe_n(oe_n), .ale(ale), .addr(addr), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .cfg_valid(cfg_valid), .muxed_mode(muxed_mode),
        .bus_32(bus_32), .little_endian(little_endian), .acc_idx(acc_idx),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .q_rd(q_rd), .q_rd_bytes(q_rd_bytes), .q_wr(q_wr), .q_wr_bytes(q_wr_bytes),
        .q_wr_count(q_wr_count));

    hbcbl_host_model u_hbcbl_host_model (
        .core_clk(core_clk), .lanes(data_in), .data_oe(data_oe), .cs_n(cs_n),
        .we_n(we_n), .oe_n(oe_n), .ale(ale), .addr(addr), .host_d(host_d));

    always @(posedge core_clk) begin
        if ((q_rd | q_wr | reg_rd | reg_wr) === 1'b1) last_idx = acc_idx;
        if (q_rd === 1'b1) n_qrd++;
        if (reg_rd === 1'b1) n_rrd++;
        if (reg_wr === 1'b1) begin
            n_rwr++;
            last_rwd = reg_wdata;
        end
        if (q_wr === 1'b1) begin
            n_qwr++;
            last_qwb = q_wr_bytes;
            last_qwc = q_wr_count;
        end
    end

    function automatic logic [31:0] exp_lanes(input logic w, input logic le,
                                              input logic [31:0] b);
        case ({w, le})
            2'b00: return {16'h0, b[7:0], b[15:8]};
            2'b01: return {16'h0, b[15:8], b[7:0]};
            2'b10: return {b[7:0], b[15:8], b[23:16], b[31:24]};
            default: return b;
        endcase
    endfunction

    task automatic tally_and_finish;
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic hrd(input logic [3:0] idx, output logic [31:0] v);
        logic ok;
        u_hbcbl_host_model.rd(cm, idx, v, last_oe, ok);
        v = v & (cw ? DOE_32 : DOE_16);
        if (ok !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t read data never driven", $time);
            tally_and_finish();
        end
    endtask

    task automatic do_reset;
        tick(1);
        srst = 1'b1;
        {mux_s, w_s, le_s} = {cm, cw, cl};
        tick(5);
        srst = 1'b0;
        tick(4);
        {mux_s, w_s, le_s} = ~{cm, cw, cl};
        tick(2);
    endtask

    task automatic scn_straps;
        chk({28'h0, cfg_valid, muxed_mode, bus_32, little_endian},
            {28'h0, 1'b1, cm, cw, cl});
    endtask

    task automatic scn_queue;
        logic [31:0] v;
        int r0, w0;
        r0 = n_qrd;
        w0 = n_qwr;
        q_rd_bytes = 32'h0F0E0D0C;
        hrd(4'h2, v);
        chk(v, exp_lanes(cw, cl, 32'h0F0E0D0C));
        chk(last_oe, cw ? DOE_32 : DOE_16);
        chk({28'h0, last_idx}, 32'h2);
        u_hbcbl_host_model.wr(cm, 4'h1, exp_lanes(cw, cl, 32'h03020100));
        chk(last_qwb & (cw ? DOE_32 : DOE_16), cw ? 32'h03020100 : 32'h00000100);
        chk({29'h0, last_qwc}, {29'h0, cw ? Q_CNT_32 : Q_CNT_16});
        chk(n_qrd - r0 + n_qwr - w0, 32'h2);
    endtask

    task automatic scn_reg;
        logic [31:0] v;
        int r0, w0;
        r0 = n_rrd;
        w0 = n_rwr;
        reg_rdata = 16'h1C3A;
        hrd(4'hA, v);
        chk(v, 32'h00001C3A);
        chk({28'h0, last_idx}, 32'hA);
        u_hbcbl_host_model.wr(cm, 4'hB, 32'hDEAD2B47);
        chk({16'h0, last_rwd}, 32'h00002B47);
        chk({28'h0, last_idx}, 32'hB);
        chk(n_rrd - r0 + n_rwr - w0, 32'h2);
    endtask

    task automatic scn_id;
        logic [31:0] v;
        int t0;
        t0 = n_qrd + n_qwr + n_rrd + n_rwr;
        hrd(ID_IDX, v);
        chk(v, {16'h0, ID_VAL});
        u_hbcbl_host_model.wr(cm, ID_IDX, 32'h0000FFFF);
        hrd(ID_IDX, v);
        chk(v, {16'h0, ID_VAL});
        chk(n_qrd + n_qwr + n_rrd + n_rwr - t0, 32'h0);
    endtask

    initial begin
        for (int k = 0; k < 4; k++) begin
            cm = k[0];
            cw = k[1];
            cl = k[0] ^ k[1];
            do_reset();
            scn_straps();
            scn_queue();
            scn_reg();
            scn_id();
            scn_straps();
        end
        tally_and_finish();
    end
endmodule
